// ---- pkg/cwd_pkg.sv ----
// Operation
// [RULE_01] Word is 12 bits; top two read one
// [RULE_02] Blank or erased word reads all ones
// [RULE_03] Bit 9 enables 18 ms reset delay
// [RULE_04] Bit 8 enables brown-out reset
// [RULE_05] Bit 7 low protects self-writable memory
// [RULE_06] Bit 6 picks 8 or 4 MHz
// [RULE_07] Bit 5 makes shared pin master clear
// [RULE_08] Bit 4 low protects program memory
// [RULE_09] Bit 3 enables the watchdog
// [RULE_10] Crystal modes always take 18 ms delay
// [RULE_11] Code 011 external clock, pin I/O, short
// [RULE_12] Codes 100/101 internal RC, 101 drives clock
// [RULE_13] Codes 110/111 external RC, 111 drives clock
// [RULE_14] Delay enable stretches non-crystal start-up
// [RULE_15] Calibration literal loads work value, pc wraps
// [RULE_16] Calibration word always readable, never protected
// [RULE_17] Only trim bits 7:1 adjust oscillator
// [RULE_18] Software writes trim bit 0 as zero
// [RULE_19] Programmer saves calibration before erase
// [RULE_20] Word latched while reset is held
package cwd_pkg;
    localparam int CWD_CLK_MHZ = 200;
    localparam int CWD_LONG_DELAY_MS = 18;
    localparam int CWD_SHORT_DELAY_US = 10;
    localparam int CWD_LONG_DELAY_CYC = CWD_LONG_DELAY_MS * 1000 * CWD_CLK_MHZ;
    localparam int CWD_SHORT_DELAY_CYC = CWD_SHORT_DELAY_US * CWD_CLK_MHZ;
    localparam int CWD_CNT_W = 22;

    // Register byte offsets
    localparam logic [7:0] CWD_OFS_FUSE_STORE = 8'h00;
    localparam logic [7:0] CWD_OFS_FUSE_ACTIVE = 8'h04;
    localparam logic [7:0] CWD_OFS_CAL_STORE = 8'h08;
    localparam logic [7:0] CWD_OFS_TRIM = 8'h0C;
    localparam logic [7:0] CWD_OFS_CTRL = 8'h10;
    localparam logic [7:0] CWD_OFS_STATUS = 8'h14;

    // Field positions of the option word and control register
    localparam int CWD_BIT_DELAY_EN = 9;
    localparam int CWD_BIT_BROWNOUT = 8;
    localparam int CWD_BIT_SW_PROT_N = 7;
    localparam int CWD_BIT_OSC_SPEED = 6;
    localparam int CWD_BIT_CLEAR_PIN = 5;
    localparam int CWD_BIT_PM_PROT_N = 4;
    localparam int CWD_BIT_WATCHDOG = 3;
    localparam int CWD_CTRL_ERASE = 0;
    localparam int CWD_CTRL_RESTART = 1;

    // Reset values: erased storage reads all ones
    localparam logic [11:0] CWD_FUSE_BLANK = 12'hFFF;
    localparam logic [11:0] CWD_FUSE_UNIMPL = 12'hC00;
    localparam logic [7:0] CWD_CAL_BLANK = 8'hFF;
    localparam logic [6:0] CWD_TRIM_RESET = 7'h00;
    localparam logic [9:0] CWD_PC_VECTOR = 10'h000;

    // Oscillator mode codes
    typedef enum logic [2:0] {
        CWD_OSC_LP = 3'b000,
        CWD_OSC_XT = 3'b001,
        CWD_OSC_HS = 3'b010,
        CWD_OSC_EC = 3'b011,
        CWD_OSC_INT_IO = 3'b100,
        CWD_OSC_INT_CLK = 3'b101,
        CWD_OSC_EXT_IO = 3'b110,
        CWD_OSC_EXT_CLK = 3'b111
    } cwd_osc_e;

    typedef enum logic [1:0] {
        CWD_SEQ_LOAD = 2'b00,
        CWD_SEQ_DELAY = 2'b01,
        CWD_SEQ_CAL = 2'b10,
        CWD_SEQ_RUN = 2'b11
    } cwd_seq_e;
endpackage : cwd_pkg

// ---- verilog/cwd_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module cwd_pin_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin_in,
    output logic pin_sync
);
    logic stage1;

    // Two flops; the first is read only by the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule : cwd_pin_sync
`default_nettype wire

// ---- verilog/cwd_option_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
module cwd_option_decoder
    import cwd_pkg::*;
#(
    parameter int LONG_DELAY_CYC = CWD_LONG_DELAY_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic master_clear_input_n,
    output logic core_reset_n,
    output logic reset_delay_timer_enable,
    output logic long_startup,
    output logic brownout_reset_enable,
    output logic selfwrite_memory_protect_n,
    output logic internal_osc_speed_select,
    output logic clear_pin_function_enable,
    output logic program_memory_protect_n,
    output logic watchdog_enable,
    output logic [2:0] osc_mode_select,
    output logic instruction_clock_output,
    output logic [6:0] osc_trim,
    output logic [7:0] work_value,
    output logic [9:0] program_counter
);
    logic [11:0] fuse_store;
    logic [7:0] cal_store;
    logic [11:0] fuse_active;
    logic [6:0] trim_bits;
    cwd_seq_e seq;
    logic [CWD_CNT_W-1:0] delay_cnt;
    logic clear_pin_sync;
    logic clear_asserted;
    logic restart_req;
    logic addr_ok;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] next_rdata;
    logic crystal_mode;
    logic load_crystal;
    logic [CWD_CNT_W-1:0] delay_load;

    // Master clear pin from outside: synchronised first
    cwd_pin_sync u_clear_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(master_clear_input_n),
        .pin_sync(clear_pin_sync)
    );

    // Pin acts as reset only when its function is enabled
    assign clear_asserted = fuse_active[CWD_BIT_CLEAR_PIN] && !clear_pin_sync; // see [RULE_07]

    // Start-up length from the word being latched, so a new mode gets its own delay
    always_comb begin
        crystal_mode = (fuse_active[2:0] == CWD_OSC_LP) || (fuse_active[2:0] == CWD_OSC_XT)
            || (fuse_active[2:0] == CWD_OSC_HS);
        load_crystal = (fuse_store[2:0] == CWD_OSC_LP) || (fuse_store[2:0] == CWD_OSC_XT)
            || (fuse_store[2:0] == CWD_OSC_HS);
        if (load_crystal) begin
            delay_load = CWD_CNT_W'(LONG_DELAY_CYC); // see [RULE_10]
        end else if (fuse_store[CWD_BIT_DELAY_EN]) begin
            delay_load = CWD_CNT_W'(LONG_DELAY_CYC); // see [RULE_03] see [RULE_14]
        end else begin
            delay_load = CWD_CNT_W'(CWD_SHORT_DELAY_CYC); // see [RULE_11] see [RULE_12]
        end
    end

    // Bus address phase: zero wait states, always OKAY
    assign addr_ok = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Latch write address for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_ofs <= haddr[7:0];
        end
    end

    // Read data selected at address phase, held through data phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            CWD_OFS_FUSE_STORE: next_rdata = {20'h0_0000, fuse_store};
            CWD_OFS_FUSE_ACTIVE: next_rdata = {20'h0_0000, fuse_active};
            CWD_OFS_CAL_STORE: next_rdata = {24'h00_0000, cal_store}; // see [RULE_16]
            CWD_OFS_TRIM: next_rdata = {24'h00_0000, trim_bits, 1'b0}; // see [RULE_17]
            CWD_OFS_STATUS: next_rdata = {16'h0000, work_value, 5'h00, seq, core_reset_n};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Nonvolatile option word; upper two bits stay one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_store <= CWD_FUSE_BLANK; // see [RULE_02]
        end else if (wr_pend && wr_ofs == CWD_OFS_CTRL && hwdata[CWD_CTRL_ERASE]) begin
            fuse_store <= CWD_FUSE_BLANK; // see [RULE_02]
        end else if (wr_pend && wr_ofs == CWD_OFS_FUSE_STORE) begin
            fuse_store <= hwdata[11:0] | CWD_FUSE_UNIMPL; // see [RULE_01]
        end
    end

    // Calibration literal at the last program location; erase wipes it too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_store <= CWD_CAL_BLANK;
        end else if (wr_pend && wr_ofs == CWD_OFS_CTRL && hwdata[CWD_CTRL_ERASE]) begin
            cal_store <= CWD_CAL_BLANK; // see [RULE_19]
        end else if (wr_pend && wr_ofs == CWD_OFS_CAL_STORE) begin
            cal_store <= hwdata[7:0];
        end
    end

    // Trim keeps bits 7:1 only; bit 0 is not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_bits <= CWD_TRIM_RESET;
        end else if (wr_pend && wr_ofs == CWD_OFS_TRIM) begin
            trim_bits <= hwdata[7:1]; // see [RULE_17] see [RULE_18]
        end
    end

    assign restart_req = wr_pend && wr_ofs == CWD_OFS_CTRL && hwdata[CWD_CTRL_RESTART];

    // Reset sequence: latch, delay, calibration load, run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq <= CWD_SEQ_LOAD;
            delay_cnt <= '0;
        end else if (restart_req || (clear_asserted && seq != CWD_SEQ_LOAD)) begin
            seq <= CWD_SEQ_LOAD; // see [RULE_07]
            delay_cnt <= '0;
        end else begin
            unique case (seq)
                CWD_SEQ_LOAD: begin
                    if (!clear_asserted) begin
                        seq <= CWD_SEQ_DELAY;
                        delay_cnt <= delay_load;
                    end
                end
                CWD_SEQ_DELAY: begin
                    if (delay_cnt <= CWD_CNT_W'(1)) begin
                        seq <= CWD_SEQ_CAL;
                    end
                    delay_cnt <= delay_cnt - CWD_CNT_W'(1);
                end
                CWD_SEQ_CAL: seq <= CWD_SEQ_RUN;
                CWD_SEQ_RUN: seq <= CWD_SEQ_RUN;
            endcase
        end
    end

    // Option word copied while the core is held in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_active <= CWD_FUSE_BLANK;
        end else if (seq == CWD_SEQ_LOAD) begin
            fuse_active <= fuse_store; // see [RULE_20]
        end
    end

    // Decoded settings, refreshed one cycle after the word latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_delay_timer_enable <= 1'b1;
            brownout_reset_enable <= 1'b1;
            selfwrite_memory_protect_n <= 1'b1;
            internal_osc_speed_select <= 1'b1;
            clear_pin_function_enable <= 1'b1;
            program_memory_protect_n <= 1'b1;
            watchdog_enable <= 1'b1;
            osc_mode_select <= CWD_OSC_EXT_CLK;
            instruction_clock_output <= 1'b1;
            long_startup <= 1'b1;
        end else begin
            reset_delay_timer_enable <= fuse_active[CWD_BIT_DELAY_EN]; // see [RULE_03]
            brownout_reset_enable <= fuse_active[CWD_BIT_BROWNOUT]; // see [RULE_04]
            selfwrite_memory_protect_n <= fuse_active[CWD_BIT_SW_PROT_N]; // see [RULE_05]
            internal_osc_speed_select <= fuse_active[CWD_BIT_OSC_SPEED]; // see [RULE_06]
            clear_pin_function_enable <= fuse_active[CWD_BIT_CLEAR_PIN]; // see [RULE_07]
            program_memory_protect_n <= fuse_active[CWD_BIT_PM_PROT_N]; // see [RULE_08]
            watchdog_enable <= fuse_active[CWD_BIT_WATCHDOG]; // see [RULE_09]
            osc_mode_select <= fuse_active[2:0];
            // Clock output only in the two RC modes with the low code bit set
            instruction_clock_output <= (fuse_active[2:0] == CWD_OSC_INT_CLK)
                || (fuse_active[2:0] == CWD_OSC_EXT_CLK); // see [RULE_12] see [RULE_13]
            long_startup <= crystal_mode || fuse_active[CWD_BIT_DELAY_EN]; // see [RULE_10]
        end
    end

    // Calibration literal executes at the vector, then pc wraps to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_value <= 8'h00;
            program_counter <= CWD_PC_VECTOR;
        end else if (seq == CWD_SEQ_CAL) begin
            work_value <= cal_store; // see [RULE_15]
            program_counter <= CWD_PC_VECTOR; // see [RULE_15]
        end
    end

    // Core leaves reset once the calibration step is done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_reset_n <= 1'b0;
        end else begin
            core_reset_n <= (seq == CWD_SEQ_CAL) || (seq == CWD_SEQ_RUN && !restart_req
                && !clear_asserted);
        end
    end

    // Trim output follows the stored bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_trim <= CWD_TRIM_RESET;
        end else begin
            osc_trim <= trim_bits; // see [RULE_17]
        end
    end
endmodule : cwd_option_decoder
`default_nettype wire

// ---- verif/cwd_option_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module cwd_option_monitor
    import cwd_pkg::*;
#(
    parameter int LONG_DELAY_CYC = CWD_LONG_DELAY_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic master_clear_input_n,
    input wire logic core_reset_n,
    input wire logic reset_delay_timer_enable,
    input wire logic long_startup,
    input wire logic clear_pin_function_enable,
    input wire logic watchdog_enable,
    input wire logic [2:0] osc_mode_select,
    input wire logic instruction_clock_output,
    input wire logic [9:0] program_counter
);
    // Read address phase taken by the slave
    logic rd_ph;
    assign rd_ph = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Decoded outputs against the latched word
    property p_instruction_clock_output;
        instruction_clock_output == (osc_mode_select[2] && osc_mode_select[0]); endproperty
    a_instruction_clock_output: assert property (p_instruction_clock_output) else $error("clock out mismatch");
    property p_long;
        long_startup == (osc_mode_select < 3'd3 || reset_delay_timer_enable); endproperty
    a_long: assert property (p_long) else $error("long start-up mismatch");
    property p_pc; $rose(core_reset_n) |-> program_counter == 10'h000; endproperty
    a_pc: assert property (p_pc) else $error("core released off vector");
    property p_master_clear_input_n;
        (clear_pin_function_enable && !master_clear_input_n) [*6] |-> !core_reset_n; endproperty
    a_master_clear_input_n: assert property (p_master_clear_input_n) else $error("clear pin ignored");
    property p_trim;
        rd_ph && haddr[7:0] == 8'h0C |=> hrdata[0] == 1'b0 && hrdata[31:8] == 24'h0; endproperty
    a_trim: assert property (p_trim) else $error("trim read bad");
    property p_store; rd_ph && haddr[7:0] == 8'h00 |=> hrdata[11:10] == 2'b11; endproperty
    a_store: assert property (p_store) else $error("store top bits not one");
    property p_active; rd_ph && haddr[7:0] == 8'h04 && core_reset_n |=>
        hrdata[11:10] == 2'b11 && hrdata[3:0] == {watchdog_enable, osc_mode_select}; endproperty
    a_active: assert property (p_active) else $error("active word mismatch");
    property p_hold; core_reset_n && $past(core_reset_n) |-> $stable({reset_delay_timer_enable,
        clear_pin_function_enable, watchdog_enable, osc_mode_select}); endproperty
    a_hold: assert property (p_hold) else $error("setting moved while running");
    // Main scenarios
    c_long: cover property ($rose(core_reset_n) && long_startup);
    c_trim: cover property (rd_ph && haddr[7:0] == 8'h0C);
    c_pin: cover property (!clear_pin_function_enable && !master_clear_input_n && core_reset_n);
endmodule : cwd_option_monitor
bind cwd_option_decoder cwd_option_monitor #(.LONG_DELAY_CYC(LONG_DELAY_CYC)) mon_u (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .master_clear_input_n,
    .core_reset_n, .reset_delay_timer_enable, .long_startup, .clear_pin_function_enable,
    .watchdog_enable, .osc_mode_select, .instruction_clock_output, .program_counter);
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cwd_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, master_clear_input_n;
    logic core_reset_n, reset_delay_timer_enable, long_startup, brownout_reset_enable;
    logic selfwrite_memory_protect_n, internal_osc_speed_select, clear_pin_function_enable;
    logic program_memory_protect_n, watchdog_enable, instruction_clock_output;
    logic [31:0] haddr, hwdata, hrdata, rd, cal_saved;
    logic [1:0] htrans;
    logic [2:0] hsize, osc_mode_select;
    logic [6:0] osc_trim;
    logic [7:0] work_value;
    logic [9:0] program_counter, flags;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    assign hready = hreadyout;
    assign flags = {reset_delay_timer_enable, brownout_reset_enable, selfwrite_memory_protect_n,
        internal_osc_speed_select, clear_pin_function_enable, program_memory_protect_n,
        watchdog_enable, osc_mode_select};
    cwd_option_decoder #(.LONG_DELAY_CYC(3000)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .master_clear_input_n,
        .core_reset_n, .reset_delay_timer_enable, .long_startup, .brownout_reset_enable,
        .selfwrite_memory_protect_n, .internal_osc_speed_select, .clear_pin_function_enable,
        .program_memory_protect_n, .watchdog_enable, .osc_mode_select, .instruction_clock_output,
        .osc_trim, .work_value, .program_counter);
    // Clock of 5 ns
    always #2.5 hclk = ~hclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One single transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    // Store a word, restart and time the hold in reset
    task automatic cfg(input logic [11:0] w);
        int n;
        logic lng;
        n = 0;
        lng = (w[2:0] < 3'd3) || w[9];
        bus(1'b1, CWD_OFS_FUSE_STORE, {20'h0, w});
        bus(1'b1, CWD_OFS_CTRL, 32'h0000_0002);
        while (core_reset_n !== 1'b0 && n < 8) begin
            @(posedge hclk);
            n++;
        end
        while (core_reset_n !== 1'b1 && n < 9000) begin
            @(posedge hclk);
            n++;
        end
        check({n > 2500, n > 1000}, {lng, 1'b1});
        check(flags, w[9:0]);
        check({instruction_clock_output, long_startup}, {w[2] & w[0], lng});
        check({work_value, program_counter}, {8'hA5, 10'h000});
        bus(1'b0, CWD_OFS_FUSE_ACTIVE, 32'h0);
        check(rd, {20'h0, 2'b11, w[9:0]});
        bus(1'b0, CWD_OFS_CAL_STORE, 32'h0);
        check(rd, 32'h0000_00A5);
    endtask : cfg
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            end_of_test();
        end
    end
    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        master_clear_input_n = 1'b1;
        repeat (6) @(posedge hclk);
        check({flags, core_reset_n}, {10'h3FF, 1'b0});
        hresetn <= 1'b1;
        bus(1'b0, CWD_OFS_FUSE_STORE, 32'h0);
        check(rd, 32'h0000_0FFF);
        bus(1'b1, CWD_OFS_CAL_STORE, 32'h0000_00A5);
        for (int i = 0; i < 16; i++) begin
            cfg({2'b00, i[3], i[3] ? 6'b10_1011 : 6'b01_0101, i[2:0]});
        end
        master_clear_input_n <= 1'b0;
        repeat (8) @(posedge hclk);
        check(core_reset_n, 1'b1);
        master_clear_input_n <= 1'b1;
        cfg(12'h03C);
        master_clear_input_n <= 1'b0;
        repeat (6) @(posedge hclk);
        check(core_reset_n, 1'b0);
        master_clear_input_n <= 1'b1;
        // Software keeps trim bit 0 at zero
        bus(1'b1, CWD_OFS_TRIM, 32'h0000_00FE);
        bus(1'b0, CWD_OFS_TRIM, 32'h0);
        check({rd, osc_trim}, {32'h0000_00FE, 7'h7F});
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        // Save the calibration literal before the erase wipes it
        bus(1'b0, CWD_OFS_CAL_STORE, 32'h0);
        cal_saved = rd;
        bus(1'b1, CWD_OFS_CTRL, 32'h0000_0001);
        bus(1'b0, CWD_OFS_FUSE_STORE, 32'h0);
        check(rd, 32'h0000_0FFF);
        bus(1'b0, CWD_OFS_CAL_STORE, 32'h0);
        check(rd, 32'h0000_00FF);
        // Restore the saved literal after the erase
        bus(1'b1, CWD_OFS_CAL_STORE, cal_saved);
        bus(1'b0, CWD_OFS_CAL_STORE, 32'h0);
        check(rd, 32'h0000_00A5);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
